// ==== bench/smc_host_model.sv ====
// Host controller model issuing register command frames on the serial link
`timescale 1ns/1ns
module smc_host_model (
  // Serial link
  output logic sclk,
  output logic cs_b,
  output logic [3:0] host_io,
  // Resolved pin levels
  input wire logic [3:0] io_w
);
  import smc_pkg::*;
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    host_io = 4'h9;
  end
  // Released lines toggle; io3 stays high since it may be a reset input
  task automatic idle();
    host_io = (~host_io & 4'h7) | 4'h8;
  endtask
  task automatic tick();
    #3 sclk = 1'b1;
    #3 sclk = 1'b0;
  endtask
  task automatic start();
    #1 cs_b = 1'b0;
    #3;
  endtask
  task automatic close();
    #3 cs_b = 1'b1;
    host_io = 4'h9;
    #12;
  endtask
  // MSB first, w bits per clock, higher pin carries the higher bit
  task automatic send(input logic [31:0] v, input int n, input int w);
    logic [3:0] m;
    m = (w == 4) ? 4'hf : (w == 2) ? 4'h3 : 4'h1;
    for (int k = n; k > 0; k -= w) begin
      host_io = (4'(v >> (k - w)) & m) | (~host_io & ~m & 4'h7) | (~m & 4'h8);
      tick();
    end
  endtask
  task automatic wr(input int w, input logic [23:0] a, input logic [7:0] d, input bit keep);
    start();
    send({24'h0000_00, SMC_OP_WRITE_ANY}, 8, w);
    send({8'h00, a}, 24, w);
    send({24'h0000_00, d}, 8, w);
    if (!keep) close();
  endtask
  task automatic rd(input int w, input logic [7:0] op, input logic [23:0] a, input int lat,
      output logic [7:0] d);
    start();
    send({24'h0000_00, op}, 8, w);
    if (op == SMC_OP_READ_ANY) begin
      send({8'h00, a}, 24, w);
      // One full clock per dummy whatever the width
      repeat (lat) begin
        idle();
        tick();
      end
    end
    d = 8'h00;
    // Sampled while the clock is low, right after the falling edge
    for (int k = 0; k < 8; k += w) begin
      d = (w == 1) ? {d[6:0], io_w[1]} : (w == 2) ? {d[5:0], io_w[1:0]} : {d[3:0], io_w};
      idle();
      tick();
    end
    close();
  endtask
endmodule

// ==== bench/smc_iface_cfg_bench.sv ====
// Self-checking bench for the interface configuration block
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module smc_iface_cfg_bench;
  import smc_pkg::*;
  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] c2;
    smc_proto_t pr;
    logic qw;
    logic xq;
    logic wpe;
    smc_pin_fn_t pf;
  } smc_row_t;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wp_b = 1'b0;
  logic rst_pin = 1'b1;
  logic sclk;
  logic cs_b;
  logic [3:0] host_io;
  logic [3:0] io_i;
  logic [3:0] io_o;
  logic [3:0] io_oe;
  smc_proto_t proto_o;
  smc_proto_t prv;
  smc_pin_fn_t pin_fn_o;
  logic quad_width_o;
  logic ext_quad_o;
  logic wp_b_eff_o;
  logic pin_reset_b_o;
  logic [3:0] latency_o;
  logic [7:0] d;
  smc_row_t rows [10];
  int bad_count = 0;
  int checked = 0;
  int cw = 1;
  always #5 sys_clk = ~sys_clk;
  // Pin level from both parties; rst_pin pulls the shared pin low
  assign io_i = ((io_oe & io_o) | (~io_oe & host_io)) & {rst_pin, 3'h7};
  smc_iface_cfg DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .io_i(io_i), .io_o(io_o),
    .io_oe(io_oe), .wp_b(wp_b), .proto_o(proto_o), .quad_width_o(quad_width_o),
    .ext_quad_o(ext_quad_o), .wp_b_eff_o(wp_b_eff_o), .pin_fn_o(pin_fn_o),
    .pin_reset_b_o(pin_reset_b_o), .latency_o(latency_o)
  );
  smc_host_model HOST (.sclk(sclk), .cs_b(cs_b), .host_io(host_io), .io_w(io_i));
  function automatic int wid(input smc_proto_t p);
    return (p == SMC_PROTO_QUAD) ? 4 : (p == SMC_PROTO_DUAL) ? 2 : 1;
  endfunction
  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wrap_up();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #900_000;
    bad_count++;
    wrap_up();
  end
  initial begin
    // Dual and quad rows keep latency two or more
    // Quad-width goes in through the row writes before any wide read
    rows[0] = '{8'h00, 8'h00, SMC_PROTO_SINGLE, 1'b0, 1'b0, 1'b0, SMC_PIN_NONE};
    rows[1] = '{8'h02, 8'h00, SMC_PROTO_SINGLE, 1'b1, 1'b1, 1'b1, SMC_PIN_NONE};
    rows[2] = '{8'h52, 8'h20, SMC_PROTO_SINGLE, 1'b1, 1'b1, 1'b1, SMC_PIN_RESET};
    rows[3] = '{8'h00, 8'h20, SMC_PROTO_SINGLE, 1'b0, 1'b0, 1'b0, SMC_PIN_RESET};
    rows[4] = '{8'h30, 8'h10, SMC_PROTO_DUAL, 1'b0, 1'b0, 1'b0, SMC_PIN_NONE};
    rows[5] = '{8'h22, 8'h30, SMC_PROTO_DUAL, 1'b0, 1'b0, 1'b1, SMC_PIN_RESET};
    rows[6] = '{8'h20, 8'h40, SMC_PROTO_QUAD, 1'b0, 1'b0, 1'b1, SMC_PIN_NONE};
    rows[7] = '{8'h70, 8'h60, SMC_PROTO_QUAD, 1'b0, 1'b0, 1'b1, SMC_PIN_RESET};
    rows[8] = '{8'h02, 8'h50, SMC_PROTO_SINGLE, 1'b1, 1'b1, 1'b1, SMC_PIN_NONE};
    rows[9] = '{8'hf0, 8'h00, SMC_PROTO_SINGLE, 1'b0, 1'b0, 1'b0, SMC_PIN_NONE};
    settle(10);
    rst_b = 1'b1;
    settle(10);
    prv = SMC_PROTO_SINGLE;
    for (int i = 0; i < 10; i++) begin
      HOST.wr(cw, SMC_ADDR_CFG1_V, rows[i].c1, 1'b0);
      HOST.wr(cw, SMC_ADDR_CFG2_V, rows[i].c2, 1'b1);
      settle(8);
      `CHK(proto_o, prv)
      HOST.close();
      settle(8);
      `CHK(proto_o, rows[i].pr)
      `CHK(quad_width_o, rows[i].qw)
      `CHK(ext_quad_o, rows[i].xq)
      `CHK(wp_b_eff_o, rows[i].wpe)
      `CHK(pin_fn_o, rows[i].pf)
      `CHK(pin_reset_b_o, 1'b1)
      `CHK(latency_o, rows[i].c1[7:4])
      prv = rows[i].pr;
      cw = wid(prv);
      HOST.rd(cw, SMC_OP_READ_CFG2, 24'h00_0000, 0, d);
      `CHK(d, rows[i].c2)
      HOST.rd(cw, SMC_OP_READ_ANY, SMC_ADDR_CFG2_V, int'(rows[i].c1[7:4]), d);
      `CHK(d, rows[i].c2)
    end
    wp_b = 1'b1;
    settle(8);
    `CHK(wp_b_eff_o, 1'b1)
    // Shared pin low with chip select high: no effect unless the alternate is on
    rst_pin = 1'b0;
    settle(8);
    `CHK(pin_reset_b_o, 1'b1)
    rst_pin = 1'b1;
    HOST.wr(1, SMC_ADDR_CFG2_V, 8'h20, 1'b0);
    settle(8);
    rst_pin = 1'b0;
    settle(8);
    `CHK(pin_reset_b_o, 1'b0)
    rst_pin = 1'b1;
    settle(8);
    `CHK(pin_reset_b_o, 1'b1)
    // Non-volatile address, reserved bits ignored, both protocol bits set
    HOST.wr(1, SMC_ADDR_CFG2_NV, 8'hff, 1'b0);
    settle(8);
    `CHK(proto_o, SMC_PROTO_SINGLE)
    HOST.rd(1, SMC_OP_READ_ANY, SMC_ADDR_CFG2_NV, 15, d);
    `CHK(d, 8'h70)
    HOST.rd(1, SMC_OP_READ_ANY, SMC_ADDR_CFG2_V, 15, d);
    `CHK(d, 8'h70)
    // Unmapped places read zero and ignore writes
    HOST.wr(1, 24'h00_0010, 8'h00, 1'b0);
    HOST.rd(1, SMC_OP_READ_ANY, 24'h00_0010, 15, d);
    `CHK(d, 8'h00)
    HOST.rd(1, SMC_OP_READ_CFG2, 24'h00_0000, 0, d);
    `CHK(d, 8'h70)
    // Reset in mid-run returns every setting to its default
    rst_b = 1'b0;
    settle(4);
    `CHK(proto_o, SMC_PROTO_SINGLE)
    `CHK(pin_fn_o, SMC_PIN_NONE)
    `CHK(latency_o, 4'h0)
    `CHK(io_oe, 4'h0)
    settle(6);
    rst_b = 1'b1;
    settle(10);
    HOST.rd(1, SMC_OP_READ_CFG2, 24'h00_0000, 0, d);
    `CHK(d, 8'h00)
    HOST.rd(1, SMC_OP_READ_ANY, SMC_ADDR_CFG2_NV, 0, d);
    `CHK(d, 8'h00)
    wrap_up();
  end
endmodule

// ==== verilog/smc_iface_cfg.sv ====
// Serial port interface mode and pin function configuration
//
// Summary of operation
// - Quad-width bit widens data to four I/Os outside two-wire protocol; write-protect and shared pin become I/O2, I/O3.
// - Quad-width plus pin reset alternate: shared pin is I/O3 in single- and four-wire frames, unused in two-wire frames, reset otherwise.
// - While quad-width is set the write-protect input is ignored and reads as one.
// - Interface register written by write-any, read by its own read or read-any.
// - Interface register bits all reset to zero.
// - Four-wire protocol carries every transfer, opcodes too, four bits per clock.
// - Four-wire protocol ignores the quad-width bit, which there drives only the quad-width output.
// - Two-wire protocol alone carries every transfer two bits per clock.
// - Neither protocol bit: single-wire commands, extended quad only with quad-width.
// - Both protocol bits set falls back to single-wire; host should avoid it.
// - Without pin reset alternate the shared pin is only I/O3 in four-wire frames and in single-wire frames with quad-width.
// - With pin reset alternate the shared pin is reset unless it carries data or is in a two-wire frame with quad-width.
// - Four-bit latency code sets 0 to 15 dummy cycles on variable latency reads.
// - One dummy cycle is one full serial clock whatever the width.
// - Operation starts in single-wire command protocol.
// - Register reads return the implemented bits that were written, even unrecommended combinations.
`timescale 1ns/1ns
module smc_iface_cfg (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Serial link
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe,
  input wire logic wp_b,
  // Configuration seen by the rest of the device
  output smc_pkg::smc_proto_t proto_o,
  output logic quad_width_o,
  output logic ext_quad_o,
  output logic wp_b_eff_o,
  output smc_pkg::smc_pin_fn_t pin_fn_o,
  output logic pin_reset_b_o,
  output logic [smc_pkg::SMC_LAT_W-1:0] latency_o
);
  import smc_pkg::*;

  typedef struct packed {
    smc_phase_t phase;
    smc_proto_t proto;
    logic [4:0] bits;
    logic [7:0] op;
    logic [23:0] addr;
    logic [7:0] sh;
    logic [7:0] osh;
    logic [7:0] rdv;
    logic [3:0] io_o_q;
    logic [3:0] io_oe_q;
  } smc_link_t;

  typedef struct packed {
    logic [7:0] cfg1_q;
    logic [7:0] cfg2_nv_q;
    logic [7:0] cfg2_v_q;
  } smc_regs_t;

  typedef struct packed {
    logic quad_q;
    logic [SMC_LAT_W-1:0] lat_q;
    logic qpi_q;
    logic pin_reset_alternate_enable_q;
    logic dpi_q;
    smc_proto_t proto_q;
    logic quadw_q;
    logic extq_q;
    logic wp_q;
    smc_pin_fn_t fn_q;
    logic prst_b_q;
    logic [SMC_LAT_W-1:0] lato_q;
  } smc_sys_t;

  logic rst_n;
  logic frm_clr;
  smc_link_t lk_q;
  smc_link_t lk_d;
  smc_regs_t rg_q;
  smc_regs_t rg_d;
  smc_sys_t sy_q;
  smc_sys_t sy_d;
  logic [SMC_SYNC_W-1:0] sy_in;
  logic [SMC_SYNC_W-1:0] sy_out;
  logic cs_s;
  logic io3_s;
  logic wp_s;
  logic wr_nv;
  logic wr_v;
  logic wr_cfg1;
  logic [7:0] wdata;
  smc_proto_t pr;
  smc_proto_t sp;
  smc_pin_fn_t fn;
  logic [4:0] wbits;
  logic [4:0] cnt_nx;
  logic [7:0] sh_in;
  logic [23:0] ad_in;
  logic [7:0] osh_nx;
  logic [SMC_LAT_W-1:0] lat;

  // Reset release through two flip-flops
  smc_sync #(.W(1)) u_rst_sync (
    .clk(sys_clk),
    .rst_n(rst_b),
    .d(1'b1),
    .q(rst_n)
  );

  // Frame state clears whenever chip select is high
  assign frm_clr = cs_b | ~rst_n;
  assign lat = rg_q.cfg1_q[SMC_CFG1_LAT_LSB +: SMC_LAT_W];

  function automatic logic [7:0] rd_val(input logic [23:0] a, input smc_regs_t r);
    if (a == SMC_ADDR_CFG2_NV) begin
      return r.cfg2_nv_q;
    end else if (a == SMC_ADDR_CFG2_V) begin
      return r.cfg2_v_q;
    end else if (a == SMC_ADDR_CFG1_V) begin
      return r.cfg1_q;
    end
    return 8'h00;
  endfunction

  always_comb begin
    lk_d = lk_q;
    wr_nv = 1'b0;
    wr_v = 1'b0;
    wr_cfg1 = 1'b0;
    wdata = 8'h00;
    // Width is fixed at the first clock of a frame from the stored bits
    pr = (lk_q.phase == SMC_PH_IDLE) ?
      smc_proto_of(rg_q.cfg2_v_q[SMC_CFG2_QPI], rg_q.cfg2_v_q[SMC_CFG2_DPI]) :
      lk_q.proto;
    unique case (pr)
      SMC_PROTO_QUAD: begin
        wbits = 5'h04;
        sh_in = {lk_q.sh[3:0], io_i[3:0]};
        ad_in = {lk_q.addr[19:0], io_i[3:0]};
        osh_nx = {lk_q.osh[3:0], 4'h0};
      end
      SMC_PROTO_DUAL: begin
        wbits = 5'h02;
        sh_in = {lk_q.sh[5:0], io_i[1:0]};
        ad_in = {lk_q.addr[21:0], io_i[1:0]};
        osh_nx = {lk_q.osh[5:0], 2'b00};
      end
      default: begin
        wbits = 5'h01;
        sh_in = {lk_q.sh[6:0], io_i[0]};
        ad_in = {lk_q.addr[22:0], io_i[0]};
        osh_nx = {lk_q.osh[6:0], 1'b0};
      end
    endcase
    cnt_nx = lk_q.bits + wbits;
    unique case (lk_q.phase)
      SMC_PH_IDLE: begin
        lk_d.proto = pr;
        lk_d.sh = sh_in;
        lk_d.bits = wbits;
        lk_d.phase = SMC_PH_OPC;
      end
      SMC_PH_OPC: begin
        lk_d.sh = sh_in;
        lk_d.bits = cnt_nx;
        if (cnt_nx == SMC_OPC_BITS) begin
          lk_d.op = sh_in;
          lk_d.bits = 5'h00;
          if (sh_in == SMC_OP_WRITE_ANY || sh_in == SMC_OP_READ_ANY) begin
            lk_d.phase = SMC_PH_ADDR;
          end else if (sh_in == SMC_OP_READ_CFG2) begin
            lk_d.rdv = rg_q.cfg2_v_q;
            lk_d.osh = rg_q.cfg2_v_q;
            lk_d.phase = SMC_PH_RDATA;
          end else begin
            lk_d.phase = SMC_PH_DONE;
          end
        end
      end
      SMC_PH_ADDR: begin
        lk_d.addr = ad_in;
        lk_d.bits = cnt_nx;
        if (cnt_nx == SMC_ADDR_BITS) begin
          lk_d.bits = 5'h00;
          if (lk_q.op == SMC_OP_WRITE_ANY) begin
            lk_d.phase = SMC_PH_WDATA;
          end else if (lat == '0) begin
            lk_d.rdv = rd_val(ad_in, rg_q);
            lk_d.osh = rd_val(ad_in, rg_q);
            lk_d.phase = SMC_PH_RDATA;
          end else begin
            lk_d.phase = SMC_PH_DUMMY;
          end
        end
      end
      SMC_PH_DUMMY: begin
        // One count per serial clock, independent of width
        lk_d.bits = lk_q.bits + 5'h01;
        if (lk_q.bits + 5'h01 == {1'b0, lat}) begin
          lk_d.bits = 5'h00;
          lk_d.rdv = rd_val(lk_q.addr, rg_q);
          lk_d.osh = rd_val(lk_q.addr, rg_q);
          lk_d.phase = SMC_PH_RDATA;
        end
      end
      SMC_PH_WDATA: begin
        lk_d.sh = sh_in;
        lk_d.bits = cnt_nx;
        if (cnt_nx == SMC_DATA_BITS) begin
          wdata = sh_in;
          wr_nv = (lk_q.addr == SMC_ADDR_CFG2_NV);
          wr_v = (lk_q.addr == SMC_ADDR_CFG2_V);
          wr_cfg1 = (lk_q.addr == SMC_ADDR_CFG1_V);
          lk_d.phase = SMC_PH_DONE;
        end
      end
      SMC_PH_RDATA: begin
        // Value repeats for as long as the host keeps clocking
        lk_d.osh = osh_nx;
        lk_d.bits = cnt_nx;
        if (cnt_nx == SMC_DATA_BITS) begin
          lk_d.osh = lk_q.rdv;
          lk_d.bits = 5'h00;
        end
      end
      default: begin
        lk_d.phase = SMC_PH_DONE;
      end
    endcase
    // Pins only driven while read data is on the wire
    lk_d.io_o_q = 4'h0;
    lk_d.io_oe_q = 4'h0;
    if (lk_d.phase == SMC_PH_RDATA) begin
      unique case (lk_d.proto)
        SMC_PROTO_QUAD: begin
          lk_d.io_o_q = lk_d.osh[7:4];
          lk_d.io_oe_q = 4'hf;
        end
        SMC_PROTO_DUAL: begin
          lk_d.io_o_q = {2'b00, lk_d.osh[7:6]};
          lk_d.io_oe_q = 4'h3;
        end
        default: begin
          lk_d.io_o_q = {2'b00, lk_d.osh[7], 1'b0};
          lk_d.io_oe_q = 4'h2;
        end
      endcase
    end
  end

  always_ff @(posedge sclk or posedge frm_clr) begin
    if (frm_clr) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  always_comb begin
    rg_d = rg_q;
    if (wr_nv) begin
      // Non-volatile write also loads the working copy
      rg_d.cfg2_nv_q = wdata & SMC_CFG2_MASK;
      rg_d.cfg2_v_q = wdata & SMC_CFG2_MASK;
    end
    if (wr_v) begin
      rg_d.cfg2_v_q = wdata & SMC_CFG2_MASK;
    end
    if (wr_cfg1) begin
      rg_d.cfg1_q = wdata & SMC_CFG1_MASK;
    end
  end

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rg_q.cfg1_q <= SMC_CFG1_RESET;
      rg_q.cfg2_nv_q <= SMC_CFG2_RESET;
      rg_q.cfg2_v_q <= SMC_CFG2_RESET;
    end else begin
      rg_q <= rg_d;
    end
  end

  assign io_o = lk_q.io_o_q;
  assign io_oe = lk_q.io_oe_q;

  // Pins and link-side bits into the system clock
  assign sy_in = {cs_b, io_i[3], wp_b, rg_q.cfg1_q[SMC_CFG1_QUAD],
    lat, rg_q.cfg2_v_q[SMC_CFG2_QPI],
    rg_q.cfg2_v_q[SMC_CFG2_PIN_RESET_ALTERNATE_ENABLE], rg_q.cfg2_v_q[SMC_CFG2_DPI]};

  smc_sync #(.W(SMC_SYNC_W)) u_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(sy_in),
    .q(sy_out)
  );

  assign cs_s = sy_out[10];
  assign io3_s = sy_out[9];
  assign wp_s = sy_out[8];

  always_comb begin
    sy_d = sy_q;
    // Register bits are only taken between frames
    if (cs_s) begin
      sy_d.quad_q = sy_out[7];
      sy_d.lat_q = sy_out[6:3];
      sy_d.qpi_q = sy_out[2];
      sy_d.pin_reset_alternate_enable_q = sy_out[1];
      sy_d.dpi_q = sy_out[0];
    end
    sp = smc_proto_of(sy_q.qpi_q, sy_q.dpi_q);
    if (cs_s) begin
      fn = sy_q.pin_reset_alternate_enable_q ? SMC_PIN_RESET : SMC_PIN_NONE;
    end else if (sp == SMC_PROTO_QUAD) begin
      fn = SMC_PIN_IO3;
    end else if (sy_q.quad_q) begin
      fn = (sp == SMC_PROTO_SINGLE) ? SMC_PIN_IO3 : SMC_PIN_NONE;
    end else begin
      fn = sy_q.pin_reset_alternate_enable_q ? SMC_PIN_RESET : SMC_PIN_NONE;
    end
    sy_d.proto_q = sp;
    sy_d.quadw_q = sy_q.quad_q && sp != SMC_PROTO_DUAL;
    sy_d.extq_q = sy_q.quad_q && sp == SMC_PROTO_SINGLE;
    sy_d.wp_q = sy_q.quad_q || sp == SMC_PROTO_QUAD || wp_s;
    sy_d.fn_q = fn;
    sy_d.prst_b_q = !(fn == SMC_PIN_RESET && !io3_s);
    sy_d.lato_q = sy_q.lat_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sy_q <= '0;
      sy_q.wp_q <= 1'b1;
      sy_q.prst_b_q <= 1'b1;
    end else begin
      sy_q <= sy_d;
    end
  end

  assign proto_o = sy_q.proto_q;
  assign quad_width_o = sy_q.quadw_q;
  assign ext_quad_o = sy_q.extq_q;
  assign wp_b_eff_o = sy_q.wp_q;
  assign pin_fn_o = sy_q.fn_q;
  assign pin_reset_b_o = sy_q.prst_b_q;
  assign latency_o = sy_q.lato_q;

  // Checks on the system side
  sequence s_idle_alt;
    cs_s && sy_q.pin_reset_alternate_enable_q;
  endsequence

  sequence s_pin_low_reset;
    fn == SMC_PIN_RESET && !io3_s;
  endsequence

  a_wp_forced: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sy_q.quad_q |=> wp_b_eff_o)
    else $error("write protect not forced high in quad width");

  a_proto_quad: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sy_q.qpi_q && !sy_q.dpi_q) |=> proto_o == SMC_PROTO_QUAD)
    else $error("four-wire protocol not selected");

  a_proto_dual: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sy_q.dpi_q && !sy_q.qpi_q) |=> proto_o == SMC_PROTO_DUAL)
    else $error("two-wire protocol not selected");

  a_proto_both: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sy_q.dpi_q == sy_q.qpi_q) |=> proto_o == SMC_PROTO_SINGLE)
    else $error("single-wire fallback missing");

  a_pin_idle_rst: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_idle_alt |=> pin_fn_o == SMC_PIN_RESET)
    else $error("shared pin not reset while deselected");

  a_pin_no_alt: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!sy_q.pin_reset_alternate_enable_q && (cs_s || sy_d.proto_q == SMC_PROTO_DUAL)) |=>
    pin_fn_o == SMC_PIN_NONE)
    else $error("shared pin has a function it should not");

  a_pin_rst_out: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pin_low_reset |=> !pin_reset_b_o)
    else $error("pin reset request not raised");

  a_cfg_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !cs_s |=> $stable({sy_q.qpi_q, sy_q.dpi_q, sy_q.pin_reset_alternate_enable_q, sy_q.quad_q}))
    else $error("mode changed inside a frame");

  // Checks on the link side
  a_reg_write: assert property (@(posedge sclk) disable iff (frm_clr)
    wr_v |=> rg_q.cfg2_v_q == $past(wdata & SMC_CFG2_MASK))
    else $error("working interface register not written");

  a_dummy_len: assert property (@(posedge sclk) disable iff (frm_clr)
    (lk_q.phase == SMC_PH_DUMMY) |-> lk_q.bits < {1'b0, lat})
    else $error("dummy count exceeds latency code");

  a_quad_drive: assert property (@(posedge sclk) disable iff (frm_clr)
    (lk_q.phase == SMC_PH_RDATA && lk_q.proto == SMC_PROTO_QUAD) |->
    io_oe == 4'hf)
    else $error("four-wire read not driving all pins");
endmodule

// ==== verilog/smc_pkg.sv ====
// Constants and types for the serial interface configuration block
package smc_pkg;
  // Register command opcodes
  localparam logic [7:0] SMC_OP_WRITE_ANY = 8'h71;
  localparam logic [7:0] SMC_OP_READ_ANY = 8'h65;
  localparam logic [7:0] SMC_OP_READ_CFG2 = 8'h3f;
  // Register addresses seen by the register commands
  localparam logic [23:0] SMC_ADDR_CFG2_NV = 24'h00_0003;
  localparam logic [23:0] SMC_ADDR_CFG2_V = 24'h07_0003;
  localparam logic [23:0] SMC_ADDR_CFG1_V = 24'h07_0002;
  // Reset values and implemented-bit masks
  localparam logic [7:0] SMC_CFG1_RESET = 8'h00;
  localparam logic [7:0] SMC_CFG2_RESET = 8'h00;
  localparam logic [7:0] SMC_CFG1_MASK = 8'hf2;
  localparam logic [7:0] SMC_CFG2_MASK = 8'h70;
  // Field positions
  localparam int SMC_CFG1_QUAD = 1;
  localparam int SMC_CFG1_LAT_LSB = 4;
  localparam int SMC_LAT_W = 4;
  localparam int SMC_CFG2_QPI = 6;
  localparam int SMC_CFG2_PIN_RESET_ALTERNATE_ENABLE = 5;
  localparam int SMC_CFG2_DPI = 4;
  // Frame field lengths in bits
  localparam logic [4:0] SMC_OPC_BITS = 5'h08;
  localparam logic [4:0] SMC_ADDR_BITS = 5'h18;
  localparam logic [4:0] SMC_DATA_BITS = 5'h08;
  // Width of the crossing into the system clock
  localparam int SMC_SYNC_W = 11;

  typedef enum logic [1:0] {
    SMC_PROTO_SINGLE,
    SMC_PROTO_DUAL,
    SMC_PROTO_QUAD
  } smc_proto_t;

  typedef enum logic [1:0] {
    SMC_PIN_NONE,
    SMC_PIN_IO3,
    SMC_PIN_RESET
  } smc_pin_fn_t;

  typedef enum logic [2:0] {
    SMC_PH_IDLE,
    SMC_PH_OPC,
    SMC_PH_ADDR,
    SMC_PH_DUMMY,
    SMC_PH_WDATA,
    SMC_PH_RDATA,
    SMC_PH_DONE
  } smc_phase_t;

  // Both protocol bits set falls back to single-wire command protocol
  function automatic smc_proto_t smc_proto_of(input logic four_wire_protocol_enable, input logic two_wire_protocol_enable);
    if (four_wire_protocol_enable && !two_wire_protocol_enable) begin
      return SMC_PROTO_QUAD;
    end else if (two_wire_protocol_enable && !four_wire_protocol_enable) begin
      return SMC_PROTO_DUAL;
    end
    return SMC_PROTO_SINGLE;
  endfunction
endpackage

// ==== verilog/smc_sync.sv ====
// Two flip-flop level synchroniser
`timescale 1ns/1ns
module smc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
  } smc_sync_t;

  smc_sync_t st_q;
  smc_sync_t st_d;

  always_comb begin
    st_d.s1_q = d;
    st_d.s2_q = st_q.s1_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2_q;
endmodule
